// ---- rtl/trk_cal_gain_ctrl.sv ----
// Tracking calibration masks, calibration scheduler and receive gain loop.
// Assumes all inputs synchronous to clk; cal_done comes from the
// calibration engine; detector inputs are levels per channel.
// Operation
// - Bit 12 enables observation-path wideband IQ error correction.
// - Bit 19 enables receive baseband DC offset tracking on live traffic.
// - Bit 20 enables receive analog DC offset tracking.
// - Bit 21 enables flat receive IQ error tracking, narrow and wide band.
// - Bit 22 enables gain detectors; cleared, automatic loop holds its index.
// - Bit 23 enables signal strength measurement without stopping receive data.
// - Direct FM transmit forces carrier leak and IQ balance tracking off.
// - Automatic TDD with receive frame under 1 ms disables harmonic, wideband IQ.
// - Automatic TDD with transmit frame under 1 ms disables predistort, IQ, leak.
// - Scheduler runs every enabled calibration in turn, waiting for cal_done after each start.
// - Automatic mode changes gain from peak and power detector outputs.
// - Manual mode changes gain only on register command or pins.
// - Manual mode with detectors on drives detector flags onto pins.
// - Fast attack option lowers gain in larger steps.
// - Combined option attacks and recovers in larger steps.
// - Overload reduces gain; low power raises gain.
// - Each channel has its own calibration mask.
// - High threshold exceeded starts attack; low not exceeded starts recovery.
// - Gain index stays within 187 to 255.
`timescale 1ns/10ps
module trk_cal_gain_ctrl #(
	parameter int TICK_CYCLES = trk_cal_pkg::GAIN_TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        cal_done,
	output logic             cal_start,
	output logic      [4:0]  cal_id,
	output logic             cal_chan,
	output logic      [31:0] cal_enable_ch1,
	output logic      [31:0] cal_enable_ch2,
	input  wire logic [1:0]  peak_over,
	input  wire logic [1:0]  power_over,
	input  wire logic [1:0]  peak_under,
	input  wire logic [1:0]  power_under,
	input  wire logic [1:0]  gpio_gain_up,
	input  wire logic [1:0]  gpio_gain_down,
	output logic      [1:0]  gpio_det_over,
	output logic      [1:0]  gpio_det_under,
	output logic      [1:0]  strength_meas_enable,
	output logic      [7:0]  gain_index_ch1,
	output logic      [7:0]  gain_index_ch2
);

	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_tick_check
		$error("TICK_CYCLES out of range");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [1:0][31:0]          mask_pend;
		logic [1:0][31:0]          mask_app;
		logic [1:0][31:0]          eff;
		logic [5:0]                cfg_pend;
		logic [5:0]                cfg_app;
		logic [15:0]               rx_frame;
		logic [15:0]               tx_frame;
		trk_cal_pkg::sched_state_e state;
		logic [5:0]                ptr;
		logic                      start;
		logic [4:0]                id;
		logic                      chan;
		logic [15:0]               tick_cnt;
		logic                      tick;
		logic [1:0][7:0]           gain;
		logic [1:0]                det_over;
		logic [1:0]                det_under;
		logic [1:0]                meas_en;
		logic [31:0]               rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	function automatic logic [7:0] gain_down(input logic [7:0] g, input logic [7:0] st);
		logic [8:0] diff;
		diff = {1'b0, g} - {1'b0, st};
		if (diff[8] || diff[7:0] < trk_cal_pkg::GAIN_MIN) begin
			gain_down = trk_cal_pkg::GAIN_MIN;
		end else begin
			gain_down = diff[7:0];
		end
	endfunction

	function automatic logic [7:0] gain_up(input logic [7:0] g, input logic [7:0] st);
		logic [8:0] sum;
		sum = {1'b0, g} + {1'b0, st};
		if (sum > {1'b0, trk_cal_pkg::GAIN_MAX}) begin
			gain_up = trk_cal_pkg::GAIN_MAX;
		end else begin
			gain_up = sum[7:0];
		end
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic                    found;
		logic [5:0]              idx;
		logic [1:0]              mode;
		logic                    det_on;
		logic                    cmd_wr;
		logic [7:0]              cmd_idx;
		logic [7:0]              atk;
		logic [7:0]              rec;
		logic [1:0][31:0]        gated;
		found   = 1'b0;
		idx     = 6'h00;
		mode    = 2'b00;
		det_on  = 1'b0;
		cmd_wr  = 1'b0;
		cmd_idx = 8'h00;
		atk     = 8'h00;
		rec     = 8'h00;
		gated   = s_q.mask_app;
		s_d     = s_q;
		s_d.start = 1'b0;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				trk_cal_pkg::MASK_CH1_OFF: begin
					s_d.mask_pend[0] = reg_wdata & trk_cal_pkg::MASK_VALID;
				end
				trk_cal_pkg::MASK_CH2_OFF: begin
					s_d.mask_pend[1] = reg_wdata & trk_cal_pkg::MASK_VALID;
				end
				trk_cal_pkg::CFG_OFF: begin
					s_d.cfg_pend = reg_wdata[5:0];
				end
				trk_cal_pkg::FRAME_OFF: begin
					s_d.rx_frame = reg_wdata[15:0];
					s_d.tx_frame = reg_wdata[31:16];
				end
				trk_cal_pkg::GAIN_OFF: begin
					cmd_wr  = 1'b1;
					cmd_idx = reg_wdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Forced-off gating of the applied masks
		for (int c = 0; c < 2; c++) begin
			if (s_q.cfg_app[trk_cal_pkg::CFG_TX_DIRECT_FM_BIT]) begin
				gated[c][trk_cal_pkg::TX_CARRIER_LEAK_BIT] = 1'b0;
				gated[c][trk_cal_pkg::TX_IQ_BALANCE_BIT]   = 1'b0;
			end
			if (s_q.cfg_app[trk_cal_pkg::CFG_TDD_AUTO_BIT] &&
			    s_q.rx_frame < trk_cal_pkg::FRAME_MIN_US) begin
				gated[c][trk_cal_pkg::RX_SECOND_HARMONIC_BIT] = 1'b0;
				gated[c][trk_cal_pkg::RX_WIDEBAND_IQ_BIT]     = 1'b0;
			end
			if (s_q.cfg_app[trk_cal_pkg::CFG_TDD_AUTO_BIT] &&
			    s_q.tx_frame < trk_cal_pkg::FRAME_MIN_US) begin
				gated[c][trk_cal_pkg::TX_PREDISTORT_BIT]   = 1'b0;
				gated[c][trk_cal_pkg::TX_IQ_BALANCE_BIT]   = 1'b0;
				gated[c][trk_cal_pkg::TX_CARRIER_LEAK_BIT] = 1'b0;
			end
			s_d.meas_en[c] = s_q.mask_app[c][trk_cal_pkg::RX_STRENGTH_BIT];
		end
		s_d.eff = gated;

		// Calibration scheduler; every enabled bit incl. 1, 19, 20, 21 takes turns
		case (s_q.state)
			trk_cal_pkg::SCHED_IDLE: begin
				s_d.mask_app = s_q.mask_pend;
				s_d.cfg_app  = s_q.cfg_pend;
				for (int i = 1; i <= 64; i++) begin
					idx = s_q.ptr + 6'(i);
					if (!found && s_q.eff[idx[5]][idx[4:0]]) begin
						found = 1'b1;
						s_d.ptr  = idx;
					end
				end
				if (found) begin
					s_d.start = 1'b1;
					s_d.id    = s_d.ptr[4:0];
					s_d.chan  = s_d.ptr[5];
					s_d.state = trk_cal_pkg::SCHED_RUN;
				end
			end
			trk_cal_pkg::SCHED_RUN: begin
				if (cal_done) begin
					s_d.state = trk_cal_pkg::SCHED_IDLE;
				end
			end
			default: begin
				s_d.state = trk_cal_pkg::SCHED_IDLE;
			end
		endcase

		// Gain loop tick divider
		s_d.tick = 1'b0;
		if (s_q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
			s_d.tick_cnt = 16'h0000;
			s_d.tick     = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
		end

		// Receive gain per channel
		for (int c = 0; c < 2; c++) begin
			mode   = (c == 0) ? s_q.cfg_app[3:2] : s_q.cfg_app[5:4];
			det_on = s_q.mask_app[c][trk_cal_pkg::RX_DETECTORS_BIT];
			atk = (mode == trk_cal_pkg::GAIN_MANUAL || mode == trk_cal_pkg::GAIN_AUTO) ?
				trk_cal_pkg::SLOW_STEP : trk_cal_pkg::FAST_STEP;
			rec = (mode == trk_cal_pkg::GAIN_FAST_BOTH) ?
				trk_cal_pkg::FAST_STEP : trk_cal_pkg::SLOW_STEP;
			s_d.det_over[c]  = 1'b0;
			s_d.det_under[c] = 1'b0;
			if (mode == trk_cal_pkg::GAIN_MANUAL) begin
				if (det_on) begin
					s_d.det_over[c]  = peak_over[c] | power_over[c];
					s_d.det_under[c] = peak_under[c] & power_under[c];
				end
				if (cmd_wr && reg_wdata[trk_cal_pkg::GAIN_CMD_CHAN_BIT] == c[0]) begin
					if (cmd_idx < trk_cal_pkg::GAIN_MIN) begin
						s_d.gain[c] = trk_cal_pkg::GAIN_MIN;
					end else begin
						s_d.gain[c] = cmd_idx;
					end
				end else if (gpio_gain_down[c] && !gpio_gain_up[c]) begin
					s_d.gain[c] = gain_down(s_q.gain[c], trk_cal_pkg::SLOW_STEP);
				end else if (gpio_gain_up[c] && !gpio_gain_down[c]) begin
					s_d.gain[c] = gain_up(s_q.gain[c], trk_cal_pkg::SLOW_STEP);
				end
			end else if (det_on && s_q.tick) begin
				if (peak_over[c] || power_over[c]) begin
					s_d.gain[c] = gain_down(s_q.gain[c], atk);
				end else if (peak_under[c] && power_under[c]) begin
					s_d.gain[c] = gain_up(s_q.gain[c], rec);
				end
			end
		end

		// Read data, valid only in the cycle after the strobe
		s_d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				trk_cal_pkg::MASK_CH1_OFF: s_d.rdata = s_q.mask_pend[0];
				trk_cal_pkg::MASK_CH2_OFF: s_d.rdata = s_q.mask_pend[1];
				trk_cal_pkg::CFG_OFF:      s_d.rdata = {26'h000_0000, s_q.cfg_pend};
				trk_cal_pkg::FRAME_OFF:    s_d.rdata = {s_q.tx_frame, s_q.rx_frame};
				trk_cal_pkg::GAIN_OFF:     s_d.rdata = {16'h0000, s_q.gain[1], s_q.gain[0]};
				trk_cal_pkg::STATUS_OFF: begin
					s_d.rdata = {22'h00_0000, s_q.chan, s_q.state == trk_cal_pkg::SCHED_RUN,
						3'h0, s_q.id};
				end
				trk_cal_pkg::EFF_CH1_OFF:  s_d.rdata = s_q.eff[0];
				trk_cal_pkg::EFF_CH2_OFF:  s_d.rdata = s_q.eff[1];
				default:                   s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q.mask_pend <= {trk_cal_pkg::MASK_RESET, trk_cal_pkg::MASK_RESET};
			s_q.mask_app  <= {trk_cal_pkg::MASK_RESET, trk_cal_pkg::MASK_RESET};
			s_q.eff       <= {trk_cal_pkg::MASK_RESET, trk_cal_pkg::MASK_RESET};
			s_q.cfg_pend  <= trk_cal_pkg::CFG_RESET;
			s_q.cfg_app   <= trk_cal_pkg::CFG_RESET;
			s_q.rx_frame  <= trk_cal_pkg::FRAME_RESET;
			s_q.tx_frame  <= trk_cal_pkg::FRAME_RESET;
			s_q.state     <= trk_cal_pkg::SCHED_IDLE;
			s_q.ptr       <= 6'h3F;
			s_q.start     <= 1'b0;
			s_q.id        <= 5'h00;
			s_q.chan      <= 1'b0;
			s_q.tick_cnt  <= 16'h0000;
			s_q.tick      <= 1'b0;
			s_q.gain      <= {trk_cal_pkg::GAIN_RESET, trk_cal_pkg::GAIN_RESET};
			s_q.det_over  <= 2'b00;
			s_q.det_under <= 2'b00;
			s_q.meas_en   <= 2'b00;
			s_q.rdata     <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata            = s_q.rdata;
	assign cal_start            = s_q.start;
	assign cal_id               = s_q.id;
	assign cal_chan             = s_q.chan;
	assign cal_enable_ch1       = s_q.eff[0];
	assign cal_enable_ch2       = s_q.eff[1];
	assign gpio_det_over        = s_q.det_over;
	assign gpio_det_under       = s_q.det_under;
	assign strength_meas_enable = s_q.meas_en;
	assign gain_index_ch1       = s_q.gain[0];
	assign gain_index_ch2       = s_q.gain[1];

	// ************************************************************
	// Assertions
	// ************************************************************
	a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
		((s_q.mask_pend[0] | s_q.mask_pend[1]) & ~trk_cal_pkg::MASK_VALID) == 32'h0000_0000)
		else $error("reserved mask bit set");

	a_fm_gates_tx: assert property (@(posedge clk) disable iff (!reset_n)
		$past(s_q.cfg_app[trk_cal_pkg::CFG_TX_DIRECT_FM_BIT]) |->
		!s_q.eff[0][trk_cal_pkg::TX_CARRIER_LEAK_BIT] && !s_q.eff[1][trk_cal_pkg::TX_IQ_BALANCE_BIT])
		else $error("tx tracking enabled under direct FM");

	a_rx_short_gate: assert property (@(posedge clk) disable iff (!reset_n)
		$past(s_q.cfg_app[trk_cal_pkg::CFG_TDD_AUTO_BIT] && s_q.rx_frame < trk_cal_pkg::FRAME_MIN_US)
		|-> !s_q.eff[0][trk_cal_pkg::RX_SECOND_HARMONIC_BIT] && !s_q.eff[1][trk_cal_pkg::RX_WIDEBAND_IQ_BIT])
		else $error("rx tracking enabled in short frame");

	a_tx_short_gate: assert property (@(posedge clk) disable iff (!reset_n)
		$past(s_q.cfg_app[trk_cal_pkg::CFG_TDD_AUTO_BIT] && s_q.tx_frame < trk_cal_pkg::FRAME_MIN_US)
		|-> !s_q.eff[1][trk_cal_pkg::TX_PREDISTORT_BIT] && !s_q.eff[0][trk_cal_pkg::TX_IQ_BALANCE_BIT])
		else $error("tx tracking enabled in short frame");

	a_gain_range: assert property (@(posedge clk) disable iff (!reset_n)
		s_q.gain[0] >= trk_cal_pkg::GAIN_MIN && s_q.gain[1] >= trk_cal_pkg::GAIN_MIN)
		else $error("gain index below range");

	a_hold_no_detect: assert property (@(posedge clk) disable iff (!reset_n)
		(s_q.cfg_app[3:2] != trk_cal_pkg::GAIN_MANUAL &&
		 !s_q.mask_app[0][trk_cal_pkg::RX_DETECTORS_BIT]) |=> $stable(s_q.gain[0]))
		else $error("gain moved with detectors off");

	a_manual_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(s_q.cfg_app[3:2] == trk_cal_pkg::GAIN_MANUAL && !reg_wr &&
		 gpio_gain_up[0] == gpio_gain_down[0]) |=> $stable(s_q.gain[0]))
		else $error("manual gain changed without command");

	a_start_enabled: assert property (@(posedge clk) disable iff (!reset_n)
		s_q.start |-> $past(s_q.eff[s_d.chan][s_d.id]) && s_q.state == trk_cal_pkg::SCHED_RUN)
		else $error("calibration started while not enabled");

	a_apply_boundary: assert property (@(posedge clk) disable iff (!reset_n)
		$past(s_q.state == trk_cal_pkg::SCHED_RUN) |-> $stable(s_q.mask_app) && $stable(s_q.cfg_app))
		else $error("mask changed during calibration");

	a_attack_step: assert property (@(posedge clk) disable iff (!reset_n)
		(s_q.tick && s_q.cfg_app[3:2] == trk_cal_pkg::GAIN_AUTO && peak_over[0] &&
		 s_q.mask_app[0][trk_cal_pkg::RX_DETECTORS_BIT] && s_q.gain[0] > trk_cal_pkg::GAIN_MIN)
		|=> s_q.gain[0] == $past(s_q.gain[0]) - trk_cal_pkg::SLOW_STEP)
		else $error("attack step wrong");

	a_meas_follow: assert property (@(posedge clk) disable iff (!reset_n)
		strength_meas_enable[1] == $past(s_q.mask_app[1][trk_cal_pkg::RX_STRENGTH_BIT]))
		else $error("strength enable mismatch");

endmodule

// ---- rtl/trk_cal_pkg.sv ----
// Package: offsets, field layouts, reset values and timing constants
// for the tracking calibration mask and receive gain mode block.
// Assumes a 100 MHz single clock domain.
package trk_cal_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] MASK_CH1_OFF = 8'h00;
	localparam logic [7:0] MASK_CH2_OFF = 8'h04;
	localparam logic [7:0] CFG_OFF      = 8'h08;
	localparam logic [7:0] FRAME_OFF    = 8'h0C;
	localparam logic [7:0] GAIN_OFF     = 8'h10;
	localparam logic [7:0] STATUS_OFF   = 8'h14;
	localparam logic [7:0] EFF_CH1_OFF  = 8'h18;
	localparam logic [7:0] EFF_CH2_OFF  = 8'h1C;

	// ************************************************************
	// Mask bit positions
	// ************************************************************
	localparam int TX_IQ_BALANCE_BIT      = 0;
	localparam int TX_CARRIER_LEAK_BIT    = 1;
	localparam int TX_LOOP_DELAY_BIT      = 2;
	localparam int TX_PREDISTORT_BIT      = 4;
	localparam int RX_SECOND_HARMONIC_BIT = 8;
	localparam int RX_WIDEBAND_IQ_BIT     = 9;
	localparam int OBS_WIDEBAND_IQ_BIT    = 12;
	localparam int RX_BASEBAND_OFFSET_BIT = 19;
	localparam int RX_ANALOG_OFFSET_BIT   = 20;
	localparam int RX_FLAT_IQ_BIT         = 21;
	localparam int RX_DETECTORS_BIT       = 22;
	localparam int RX_STRENGTH_BIT        = 23;
	localparam logic [31:0] MASK_VALID    = 32'h00F8_1317;
	localparam logic [31:0] MASK_RESET    = 32'h0000_0000;

	// ************************************************************
	// Configuration fields
	// ************************************************************
	localparam int CFG_TX_DIRECT_FM_BIT = 0;
	localparam int CFG_TDD_AUTO_BIT     = 1;
	localparam int CFG_MODE_CH1_LSB     = 2;
	localparam int CFG_MODE_CH2_LSB     = 4;
	localparam int CFG_WIDTH            = 6;
	localparam logic [5:0] CFG_RESET    = 6'h00;
	localparam int GAIN_CMD_CHAN_BIT    = 8;
	localparam int STATUS_BUSY_BIT      = 8;
	localparam int STATUS_CHAN_BIT      = 9;

	typedef enum logic [1:0] {
		GAIN_MANUAL      = 2'b00,
		GAIN_AUTO        = 2'b01,
		GAIN_FAST_ATTACK = 2'b10,
		GAIN_FAST_BOTH   = 2'b11
	} gain_mode_e;

	typedef enum logic [0:0] {
		SCHED_IDLE = 1'b0,
		SCHED_RUN  = 1'b1
	} sched_state_e;

	// ************************************************************
	// Gain index range, steps, timing
	// ************************************************************
	localparam logic [7:0] GAIN_MIN      = 8'hBB;
	localparam logic [7:0] GAIN_MAX      = 8'hFF;
	localparam logic [7:0] GAIN_RESET    = 8'hFF;
	localparam logic [7:0] SLOW_STEP     = 8'h01;
	localparam logic [7:0] FAST_STEP     = 8'h04;
	localparam logic [15:0] FRAME_MIN_US = 16'h03E8;
	localparam logic [15:0] FRAME_RESET  = 16'hFFFF;
	localparam int GAIN_TICK_NS          = 1000;
	localparam int CLK_PERIOD_NS         = 10;
	localparam int GAIN_TICK_CYCLES      = GAIN_TICK_NS / CLK_PERIOD_NS;

endpackage

// ---- tb/cal_engine_model.sv ----
// Calibration engine stand-in: answers every start with a done pulse.
// Assumes cal_start is a one-cycle pulse and delay is at least one.
`timescale 1ns/10ps
module cal_engine_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       cal_start,
	input  wire logic [7:0] delay,
	output logic            cal_done
);
	logic [7:0] left_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			left_q   <= 8'h00;
			cal_done <= 1'b0;
		end else begin
			cal_done <= (left_q == 8'h01);
			if (cal_start)
				left_q <= delay;
			else if (left_q != 8'h00)
				left_q <= left_q - 8'h01;
		end
	end
endmodule

// ---- tb/trk_cal_gain_ctrl_tb.sv ----
// Self-checking bench for the calibration mask and gain mode block.
// Assumes the calibration engine model sits on the start/done pair.
`timescale 1ns/10ps
module trk_cal_gain_ctrl_tb;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [31:0] cal_enable_ch1;
	logic [31:0] cal_enable_ch2;
	logic [4:0]  cal_id;
	logic [1:0]  peak_over, power_over, peak_under, power_under;
	logic [1:0]  gpio_gain_up, gpio_gain_down, gpio_det_over, gpio_det_under;
	logic [1:0]  strength_meas_enable;
	logic [7:0]  gain_index_ch1, gain_index_ch2, cal_delay;
	logic        clk, reset_n, reg_wr, reg_rd, cal_done, cal_start, cal_chan;
	int          miscompares, compares, cycles;

	trk_cal_gain_ctrl #(.TICK_CYCLES(4)) trk_cal_gain_ctrl_i (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_done(cal_done),
		.cal_start(cal_start), .cal_id(cal_id), .cal_chan(cal_chan),
		.cal_enable_ch1(cal_enable_ch1), .cal_enable_ch2(cal_enable_ch2),
		.peak_over(peak_over), .power_over(power_over), .peak_under(peak_under),
		.power_under(power_under), .gpio_gain_up(gpio_gain_up),
		.gpio_gain_down(gpio_gain_down), .gpio_det_over(gpio_det_over),
		.gpio_det_under(gpio_det_under), .strength_meas_enable(strength_meas_enable),
		.gain_index_ch1(gain_index_ch1), .gain_index_ch2(gain_index_ch2));

	cal_engine_model cal_engine_model_i (
		.clk(clk), .reset_n(reset_n), .cal_start(cal_start), .delay(cal_delay),
		.cal_done(cal_done));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp, "register read");
	endtask

	task automatic wait_en(input logic ch, input logic [31:0] exp);
		logic [31:0] seen;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1;
			seen = ch ? cal_enable_ch2 : cal_enable_ch1;
			if (seen === exp)
				break;
		end
		check(seen, exp, "effective mask");
	endtask

	task automatic wait_start(input logic [4:0] id, input logic ch);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if (cal_start === 1'b1)
				break;
		end
		check({26'h0, cal_chan, cal_id}, {26'h0, ch, id}, "calibration start");
	endtask

	task automatic t_reset();
		rd_check(trk_cal_pkg::GAIN_OFF, 32'h0000_FFFF);
		rd_check(trk_cal_pkg::MASK_CH1_OFF, 32'h0000_0000);
		rd_check(trk_cal_pkg::MASK_CH2_OFF, 32'h0000_0000);
		rd_check(8'hFC, 32'h0000_0000);
		wr(trk_cal_pkg::MASK_CH1_OFF, 32'hFFFF_FFFF);
		rd_check(trk_cal_pkg::MASK_CH1_OFF, trk_cal_pkg::MASK_VALID);
		$display("reset and reserved test done");
	endtask

	task automatic t_sched();
		int          bits [5] = '{12, 19, 20, 21, 4};
		logic [31:0] m;
		logic        ch;
		for (int k = 0; k < 5; k++) begin
			m  = 32'h0000_0001 << bits[k];
			ch = (k == 4);
			wr(trk_cal_pkg::MASK_CH1_OFF, ch ? 32'h0000_0000 : m);
			wr(trk_cal_pkg::MASK_CH2_OFF, ch ? m : 32'h0000_0000);
			wait_en(ch, m);
			wait_start(5'(bits[k]), ch);
		end
		$display("scheduler test done");
	endtask

	task automatic t_busy();
		cal_delay <= 8'd40;
		wr(trk_cal_pkg::MASK_CH2_OFF, 32'h0000_0000);
		wr(trk_cal_pkg::MASK_CH1_OFF, 32'h0000_1000);
		wait_en(1'b0, 32'h0000_1000);
		wait_start(5'd12, 1'b0);
		rd_check(trk_cal_pkg::STATUS_OFF, 32'h0000_010C);
		wr(trk_cal_pkg::MASK_CH1_OFF, 32'h0008_0000);
		repeat (10) @(posedge clk);
		#1;
		check(cal_enable_ch1, 32'h0000_1000, "mask held while busy");
		wait_en(1'b0, 32'h0008_0000);
		cal_delay <= 8'd3;
		$display("busy hold test done");
	endtask

	task automatic t_gate();
		logic [31:0] cfg [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002};
		logic [31:0] frm [4] = '{32'hFFFF_FFFF, 32'h03E7_03E8, 32'h03E8_03E7, 32'h03E8_03E8};
		logic [31:0] off [4] = '{32'h0000_0003, 32'h0000_0013, 32'h0000_0300, 32'h0000_0000};
		logic [31:0] exp;
		for (int k = 0; k < 4; k++) begin
			exp = trk_cal_pkg::MASK_VALID & ~off[k];
			wr(trk_cal_pkg::FRAME_OFF, frm[k]);
			wr(trk_cal_pkg::CFG_OFF, cfg[k]);
			wr(trk_cal_pkg::MASK_CH2_OFF, trk_cal_pkg::MASK_VALID);
			wr(trk_cal_pkg::MASK_CH1_OFF, trk_cal_pkg::MASK_VALID);
			wait_en(1'b0, exp);
			rd_check(trk_cal_pkg::EFF_CH2_OFF, exp);
			rd_check(trk_cal_pkg::CFG_OFF, cfg[k]);
			rd_check(trk_cal_pkg::FRAME_OFF, frm[k]);
		end
		wr(trk_cal_pkg::CFG_OFF, 32'h0000_0000);
		wr(trk_cal_pkg::MASK_CH2_OFF, 32'h0000_0000);
		$display("gating test done");
	endtask

	task automatic t_manual();
		wr(trk_cal_pkg::MASK_CH1_OFF, 32'h00C0_0000);
		repeat (20) @(posedge clk);
		wr(trk_cal_pkg::GAIN_OFF, 32'h0000_00C8);
		wr(trk_cal_pkg::GAIN_OFF, 32'h0000_0105);
		gpio_gain_up   <= 2'b01;
		gpio_gain_down <= 2'b10;
		@(posedge clk);
		gpio_gain_up   <= 2'b00;
		gpio_gain_down <= 2'b00;
		peak_over      <= 2'b01;
		peak_under     <= 2'b11;
		power_under    <= 2'b01;
		repeat (24) @(posedge clk);
		#1;
		check({30'h0, gpio_det_over}, 32'h0000_0001, "detector pin");
		check({30'h0, gpio_det_under}, 32'h0000_0001, "low detector pin");
		check({30'h0, strength_meas_enable}, 32'h0000_0001, "strength enable");
		check({24'h0, gain_index_ch2}, 32'h0000_00BB, "channel two gain");
		rd_check(trk_cal_pkg::GAIN_OFF, 32'h0000_BBC9);
		@(posedge clk);
		{peak_over, peak_under, power_under} <= 6'h00;
		$display("manual gain test done");
	endtask

	task automatic gstep(input logic [1:0] mode, input logic over, input logic [7:0] exp);
		wr(trk_cal_pkg::CFG_OFF, 32'h0000_0000);
		repeat (12) @(posedge clk);
		wr(trk_cal_pkg::GAIN_OFF, 32'h0000_00C8);
		wr(trk_cal_pkg::CFG_OFF, {28'h0, mode, 2'b00});
		peak_over   <= {1'b0, over & ~mode[1]};
		power_over  <= {1'b0, over & mode[1]};
		peak_under  <= {1'b0, ~over};
		power_under <= {1'b0, ~over};
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			#1;
			if (gain_index_ch1 !== 8'hC8)
				break;
		end
		check({24'h0, gain_index_ch1}, {24'h0, exp}, "gain step");
		@(posedge clk);
		{peak_over, power_over, peak_under, power_under} <= 8'h00;
	endtask

	task automatic t_auto();
		gstep(2'd1, 1'b1, 8'hC7);
		gstep(2'd1, 1'b0, 8'hC9);
		gstep(2'd2, 1'b1, 8'hC4);
		gstep(2'd2, 1'b0, 8'hC9);
		gstep(2'd3, 1'b1, 8'hC4);
		gstep(2'd3, 1'b0, 8'hCC);
		wr(trk_cal_pkg::MASK_CH1_OFF, 32'h0080_0000);
		gstep(2'd1, 1'b1, 8'hC8);
		$display("automatic gain test done");
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{peak_over, power_over, peak_under, power_under} = 8'h00;
		{gpio_gain_up, gpio_gain_down} = 4'h0;
		cal_delay = 8'd3;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_sched();
		t_busy();
		t_gate();
		t_manual();
		t_auto();
		wrap_up();
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
endmodule
